// File: tb/flash_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
// Behavioural flash device on the far side of the pins
module flash_dev_model #(
  parameter int BUSY_NS = 200,
  parameter logic [7:0] STAT_VAL = 8'hC0
) (
  // Host pins
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic read_strobe_n,
  input wire logic wp_n,
  input wire logic [7:0] io_bus,
  // Device outputs
  output logic [7:0] io_drv,
  output logic rb_low
);
  logic [7:0] cmd_q = 8'hFF;
  logic [7:0] col_q = 8'h00;
  logic [7:0] last_q = 8'h00;
  logic upper_q = 1'b0;
  int n_addr = 0;
  event go_busy;
  initial begin
    io_drv = 8'hFF;
    rb_low = 1'b0;
  end
  // Busy window; a retrigger inside it is lost, fine for one op at a time
  always @(go_busy) begin
    rb_low = 1'b1;
    #(BUSY_NS) rb_low = 1'b0;
  end
  // Latch on the write strobe rising edge with chip select low
  always @(posedge we_n) begin
    if (!ce_n && cle && (!rb_low || io_bus inside {8'hFF, 8'h70, 8'h71})) begin
      cmd_q = io_bus;
      n_addr = 0;
      upper_q = (io_bus == 8'h01);
      if (io_bus == 8'hFF || (wp_n && io_bus inside {8'h10, 8'h11, 8'hD0})) -> go_busy;
    end else if (!ce_n && ale && n_addr < 4) begin
      if (n_addr == 0) col_q = io_bus;
      n_addr++;
      if (n_addr == 4 && cmd_q inside {8'h00, 8'h01, 8'h03, 8'h50}) -> go_busy;
    end
  end
  // Next byte on each read strobe fall; released bus shows the inverse
  always @(read_strobe_n or ce_n) begin
    if (!ce_n && !read_strobe_n) begin
      last_q = (cmd_q inside {8'h70, 8'h71}) ? STAT_VAL : col_q ^ {upper_q, 7'h00};
      col_q++;
    end
    io_drv = (!ce_n && !read_strobe_n) ? last_q : ~last_q;
  end
endmodule // flash_dev_model
`default_nettype wire

// File: tb/nand_host_ctrl_props.sv
`timescale 1ns/1ps
`default_nettype none
// Pin protocol checks on the host sequencer
module nand_host_ctrl_props (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Flash pins
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic read_strobe_n,
  input wire logic [7:0] io_out,
  input wire logic io_oe,
  input wire logic ready_busy,
  // Completion
  input wire logic op_done
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Three low cycles then high
  sequence we_pulse;
    !we_n [*3] ##1 we_n;
  endsequence
  // A command byte starting its strobe
  sequence cmd_start;
    cle && $fell(we_n);
  endsequence
  a_we_width: assert property ($fell(we_n) |-> we_pulse)
    else $error("write strobe width wrong");
  a_we_select: assert property (!we_n |-> !ce_n && io_oe && read_strobe_n)
    else $error("write strobe without select");
  a_kind_excl: assert property (!we_n |-> !(cle && ale))
    else $error("both latch selects high");
  a_byte_hold: assert property ($rose(we_n) |-> $stable(io_out) && $stable({cle, ale}))
    else $error("byte changed at latch edge");
  a_cmd_legal: assert property (cmd_start |->
      io_out inside {8'h00, 8'h01, 8'h03, 8'h10, 8'h11, 8'h50, 8'h60, 8'h70, 8'h71,
      8'h80, 8'h8A, 8'h90, 8'hD0, 8'hFF}) else $error("undefined opcode");
  // Busy must already be seen for a few cycles, so a late busy edge is not blamed
  a_busy_cmds: assert property (!ready_busy [*3] ##0 cmd_start |->
      io_out inside {8'hFF, 8'h70, 8'h71}) else $error("command sent while busy");
  a_read_release: assert property (!read_strobe_n |-> !io_oe && we_n && !ce_n)
    else $error("bus driven during read strobe");
  a_done_ready: assert property (op_done |-> ready_busy && $past(ready_busy))
    else $error("done while device busy");
endmodule // nand_host_ctrl_props
bind nand_host_ctrl nand_host_ctrl_props u_props (.sys_clk(sys_clk), .rst_b(rst_b),
  .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .read_strobe_n(read_strobe_n),
  .io_out(io_out), .io_oe(io_oe), .ready_busy(ready_busy), .op_done(op_done));
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench: host sequencer against a behavioural flash
module testbench;
  localparam logic [1:0] CMD = 2'h2;
  localparam logic [1:0] ADR = 2'h1;
  localparam logic [1:0] DAT = 2'h0;
  logic sys_clk, rst_b, clk_en, op_valid, op_multi, op_last, wr_valid, wp_req_n, io_oe, rb_low;
  logic op_ready, op_done, wr_take, rd_valid, ce_n, cle, ale, we_n, read_strobe_n, wp_n;
  logic [2:0] op_code;
  logic [26:0] op_addr;
  logic [9:0] op_len;
  logic [7:0] wr_data, rd_data, io_out, io_drv;
  wire logic [7:0] io_bus;
  logic [9:0] got_q[$];
  logic [9:0] exp_q[$];
  logic [7:0] rd_q[$];
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;
  // Host drives the shared bus while enabled, else the device side
  assign io_bus = io_oe ? io_out : io_drv;
  nand_host_ctrl u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .clk_en(clk_en), .op_valid(op_valid),
    .op_code(op_code), .op_addr(op_addr), .op_multi(op_multi), .op_last(op_last),
    .op_len(op_len), .op_ready(op_ready), .op_done(op_done), .wr_data(wr_data),
    .wr_valid(wr_valid), .wr_take(wr_take), .rd_data(rd_data), .rd_valid(rd_valid),
    .wp_req_n(wp_req_n), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
    .read_strobe_n(read_strobe_n), .wp_n(wp_n), .io_out(io_out), .io_oe(io_oe),
    .io_in(io_bus), .ready_busy(!rb_low));
  flash_dev_model u_flash (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
    .read_strobe_n(read_strobe_n), .wp_n(wp_n), .io_bus(io_bus), .io_drv(io_drv),
    .rb_low(rb_low));
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Latched bytes as {cle, ale, byte}, seen on the wire itself
  always @(posedge we_n) if (!ce_n) got_q.push_back({cle, ale, io_bus});
  // Read stream capture and hang guard
  always @(posedge sys_clk) begin
    if (rd_valid === 1'b1) rd_q.push_back(rd_data);
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test();
    end
  end
  // Write stream advances one byte per take
  always @(negedge sys_clk) if (wr_take === 1'b1) wr_data <= wr_data + 8'h01;
  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] want);
    n_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  function automatic void push(input logic [1:0] k, input logic [7:0] b);
    exp_q.push_back({k, b});
  endfunction
  // Column byte unless rows only, then row bytes, the last with its top six bits low
  function automatic void push_addr(input logic [26:0] a, input logic rows_only);
    if (!rows_only) push(ADR, a[7:0]);
    push(ADR, a[16:9]);
    push(ADR, a[24:17]);
    push(ADR, {6'h00, a[26:25]});
  endfunction
  // Hold the request until taken, then bounded wait for completion
  task automatic run_op(input logic [2:0] c, input logic [26:0] a, input logic m,
                        input logic l, input logic [9:0] n);
    int t;
    t = 0;
    @(negedge sys_clk);
    op_code = c;
    op_addr = a;
    op_multi = m;
    op_last = l;
    op_len = n;
    op_valid = 1'b1;
    // A busy device refuses the request; op_ready only drops once it is taken
    do begin
      @(negedge sys_clk);
      t++;
    end while (op_ready !== 1'b0 && t < 4000);
    op_valid = 1'b0;
    while (op_done !== 1'b1 && t < 4000) begin
      @(negedge sys_clk);
      t++;
    end
    check("op done", {9'h000, op_done}, 10'h001);
    repeat (2) @(negedge sys_clk);
  endtask
  task automatic cmp_log(input string what);
    check({what, " length"}, 10'(got_q.size()), 10'(exp_q.size()));
    foreach (exp_q[i]) check(what, got_q[i], exp_q[i]);
    got_q.delete();
    exp_q.delete();
    rd_q.delete();
  endtask
  // Main read: opcode from A8, data from the addressed column onward
  task automatic t_read(input logic [26:0] a);
    push(CMD, {7'h00, a[8]});
    push_addr(a, 1'b0);
    run_op(3'h0, a, 1'b0, 1'b1, 10'h003);
    check("read count", 10'(rd_q.size()), 10'h003);
    // Column counter is a byte wide and wraps
    foreach (rd_q[i]) check("read byte", rd_q[i], 8'((a[7:0] + 8'(i)) ^ {a[8], 7'h00}));
    cmp_log("read seq");
  endtask
  task automatic t_prog(input logic last);
    logic [7:0] d;
    d = wr_data;
    push(CMD, 8'h80);
    push_addr(27'h2A5_3C11, 1'b0);
    for (int i = 0; i < 4; i++) push(DAT, d + 8'(i));
    push(CMD, last ? 8'h10 : 8'h11);
    run_op(3'h1, 27'h2A5_3C11, 1'b0, last, 10'h004);
    cmp_log("program seq");
  endtask
  // Erase: rows only, top address bits all set
  task automatic t_erase();
    push(CMD, 8'h60);
    push_addr(27'h7FF_FE00, 1'b1);
    push(CMD, 8'hD0);
    run_op(3'h2, 27'h7FF_FE00, 1'b0, 1'b1, 10'h000);
    cmp_log("erase seq");
  endtask
  task automatic t_copy(input logic m, input logic l);
    push(CMD, m ? 8'h03 : 8'h00);
    push_addr(27'h123_4067, 1'b0);
    push(CMD, 8'h8A);
    push_addr(27'h123_4067, 1'b0);
    push(CMD, l ? 8'h10 : 8'h11);
    run_op(3'h3, 27'h123_4067, m, l, 10'h000);
    cmp_log("copy-back seq");
  endtask
  // Single-opcode operations; ID adds one 00h address byte, spare read a full four-byte address
  task automatic t_short(input logic [2:0] c, input logic m, input logic [7:0] opc);
    push(CMD, opc);
    if (c == 3'h6) push(ADR, 8'h00);
    if (c == 3'h7) push_addr(27'h000_0005, 1'b0);
    run_op(c, 27'h000_0005, m, 1'b1, 10'h001);
    if (c == 3'h4) check("status byte", rd_q[0], 10'h0C0);
    cmp_log("short seq");
  endtask
  task automatic t_wp();
    wp_req_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    check("wp pin low", {9'h000, wp_n}, 10'h000);
    wp_req_n = 1'b1;
    repeat (3) @(negedge sys_clk);
    check("wp pin high", {9'h000, wp_n}, 10'h001);
  endtask
  // Clock enable low must hold every flop, the write-protect pin included
  task automatic t_freeze();
    clk_en = 1'b0;
    wp_req_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    check("frozen wp pin", {9'h000, wp_n}, 10'h001);
    clk_en = 1'b1;
    repeat (2) @(negedge sys_clk);
    check("thawed wp pin", {9'h000, wp_n}, 10'h000);
    wp_req_n = 1'b1;
    repeat (2) @(negedge sys_clk);
  endtask
  initial begin
    rst_b = 1'b0;
    clk_en = 1'b1;
    op_valid = 1'b0;
    op_code = 3'h0;
    op_addr = 27'h0;
    op_multi = 1'b0;
    op_last = 1'b1;
    op_len = 10'h000;
    wr_valid = 1'b1;
    wr_data = 8'h5A;
    wp_req_n = 1'b1;
    repeat (5) @(negedge sys_clk);
    check("reset pins", {4'h0, ce_n, we_n, read_strobe_n, cle, ale, io_oe}, 10'h038);
    rst_b = 1'b1;
    repeat (2) @(negedge sys_clk);
    t_wp();
    t_freeze();
    t_read(27'h4A5_B1F3);
    t_read(27'h0C3_12FE);
    t_prog(1'b1);
    t_prog(1'b0);
    t_erase();
    t_copy(1'b0, 1'b1);
    t_copy(1'b1, 1'b0);
    t_short(3'h4, 1'b0, 8'h70);
    t_short(3'h4, 1'b1, 8'h71);
    t_short(3'h5, 1'b0, 8'hFF);
    t_short(3'h6, 1'b0, 8'h90);
    t_short(3'h7, 1'b0, 8'h50);
    end_of_test();
  end
endmodule // testbench
`default_nettype wire

// File: verilog/nand_host_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Host sequencer: turns user operations into command/address/data byte cycles
module nand_host_ctrl #(
  parameter int ADDR_W = nand_host_pkg::ADDR_W,
  parameter int PAGE_BYTES = nand_host_pkg::PAGE_BYTES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Operation request
  input wire logic op_valid,
  input wire logic [2:0] op_code,
  input wire logic [ADDR_W-1:0] op_addr,
  input wire logic op_multi,
  input wire logic op_last,
  input wire logic [9:0] op_len,
  output logic op_ready,
  output logic op_done,
  // Write data stream
  input wire logic [7:0] wr_data,
  input wire logic wr_valid,
  output logic wr_take,
  // Read data stream
  output logic [7:0] rd_data,
  output logic rd_valid,
  // Protection
  input wire logic wp_req_n,
  // Flash pins
  output logic ce_n,
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic read_strobe_n,
  output logic wp_n,
  output logic [7:0] io_out,
  output logic io_oe,
  input wire logic [7:0] io_in,
  input wire logic ready_busy
);
  // Operation codes on op_code
  localparam logic [2:0] OPC_READ = 3'h0;
  localparam logic [2:0] OPC_PROG = 3'h1;
  localparam logic [2:0] OPC_ERASE = 3'h2;
  localparam logic [2:0] OPC_COPY = 3'h3;
  localparam logic [2:0] OPC_STATUS = 3'h4;
  localparam logic [2:0] OPC_RESET = 3'h5;
  localparam logic [2:0] OPC_ID = 3'h6;
  localparam logic [2:0] OPC_SPARE = 3'h7;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_CMD = 3'b001, S_ADDR = 3'b011, S_DATA = 3'b010,
    S_CONF = 3'b110, S_WAIT = 3'b111, S_CB2 = 3'b101, S_END = 3'b100
  } state_e;

  state_e st_q, st_d;
  logic [2:0] opc_q, opc_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic multi_q, multi_d, last_q, last_d;
  logic [9:0] len_q, len_d;
  logic [2:0] acyc_q, acyc_d;
  logic go;
  nand_host_pkg::step_s step;
  logic done;
  logic [7:0] rd_byte;
  logic [1:0] rb_sync_q;
  logic op_ready_d, op_done_d, wr_take_d, rd_valid_d, ce_d;
  logic [7:0] rd_data_d;
  logic [7:0] cmd1, abyte;
  logic [2:0] nacyc, first_acyc;
  logic is_read;

  // Ready/busy is a pin from another domain
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) rb_sync_q <= nand_host_pkg::SYNC_RESET;
    else if (clk_en) rb_sync_q <= {rb_sync_q[0], ready_busy};
  end

  // First opcode; A8 picks the page half for main reads
  always_comb begin
    is_read = 1'b0;
    case (opc_q)
      OPC_READ: begin
        cmd1 = addr_q[8] ? nand_host_pkg::OP_READ_B : nand_host_pkg::OP_READ_A;
        is_read = 1'b1;
      end
      OPC_SPARE: begin
        cmd1 = nand_host_pkg::OP_READ_C;
        is_read = 1'b1;
      end
      OPC_ID: begin
        cmd1 = nand_host_pkg::OP_READ_ID;
        is_read = 1'b1;
      end
      OPC_PROG: cmd1 = nand_host_pkg::OP_PROG;
      OPC_ERASE: cmd1 = nand_host_pkg::OP_ERASE;
      OPC_COPY: cmd1 = multi_q ? nand_host_pkg::OP_CB_MP : nand_host_pkg::OP_READ_A;
      OPC_STATUS: begin
        cmd1 = multi_q ? nand_host_pkg::OP_STATUS_MP : nand_host_pkg::OP_STATUS;
        is_read = 1'b1;
      end
      default: cmd1 = nand_host_pkg::OP_RESET;
    endcase
  end

  // Address cycle count and byte; erase skips the column cycle
  always_comb begin
    nacyc = 3'h4;
    first_acyc = 3'h0;
    if (opc_q == OPC_ERASE) first_acyc = 3'h1;
    if (opc_q == OPC_ID) nacyc = 3'h1;
    case (acyc_q)
      3'h0: abyte = addr_q[7:0];
      3'h1: abyte = addr_q[16:9];
      3'h2: abyte = addr_q[24:17];
      default: abyte = {6'h00, addr_q[26:25]};
    endcase
    if (opc_q == OPC_ID) abyte = 8'h00;
  end

  // Sequencer
  always_comb begin
    st_d = st_q;
    opc_d = opc_q;
    addr_d = addr_q;
    multi_d = multi_q;
    last_d = last_q;
    len_d = len_q;
    acyc_d = acyc_q;
    go = 1'b0;
    step = '0;
    op_ready_d = 1'b0;
    op_done_d = 1'b0;
    wr_take_d = 1'b0;
    rd_valid_d = 1'b0;
    rd_data_d = rd_data;
    ce_d = ce_n;
    case (st_q)
      S_IDLE: begin
        op_ready_d = 1'b1;
        ce_d = 1'b1;
        // Busy device takes only reset and status
        if (op_valid && op_ready && (rb_sync_q[1] || op_code == OPC_STATUS
            || op_code == OPC_RESET)) begin
          opc_d = op_code;
          addr_d = op_addr;
          multi_d = op_multi;
          last_d = op_last;
          len_d = op_len;
          op_ready_d = 1'b0;
          ce_d = 1'b0;
          st_d = S_CMD;
        end
      end
      S_CMD: begin
        go = 1'b1;
        step = '{kind: nand_host_pkg::K_CMD, byte_val: cmd1};
        acyc_d = first_acyc;
        if (done) begin
          if (opc_q == OPC_STATUS) st_d = S_DATA;
          else if (opc_q == OPC_RESET) st_d = S_WAIT;
          else st_d = S_ADDR;
        end
      end
      S_ADDR: begin
        go = 1'b1;
        step = '{kind: nand_host_pkg::K_ADDR, byte_val: abyte};
        if (done) begin
          acyc_d = acyc_q + 3'h1;
          if (acyc_q + 3'h1 == nacyc) begin
            // Copy source load makes the device busy; wait before the target phase
            if (opc_q == OPC_ERASE || (opc_q == OPC_COPY && len_q == 10'h3FF)) st_d = S_CONF;
            else if ((is_read && opc_q != OPC_ID) || opc_q == OPC_COPY) st_d = S_WAIT;
            else st_d = S_DATA;
          end
        end
      end
      S_WAIT: begin
        // Wait long enough for the synced busy low, then for its return high
        go = 1'b0;
        if (rb_sync_q[1] && !done && acyc_q == 3'h7) begin
          if (is_read) st_d = S_DATA;
          else if (opc_q == OPC_COPY && st_q == S_WAIT && len_q == 10'h3FF) st_d = S_END;
          else st_d = S_END;
        end
        acyc_d = (acyc_q == 3'h7) ? acyc_q : acyc_q + 3'h1;
        if (opc_q == OPC_COPY && rb_sync_q[1] && acyc_q == 3'h7 && len_q != 10'h3FF)
          st_d = S_CB2;
      end
      S_DATA: begin
        if (len_q == 10'h000) begin
          st_d = (opc_q == OPC_PROG) ? S_CONF : S_END;
        end else if (is_read) begin
          go = 1'b1;
          step = '{kind: nand_host_pkg::K_READ, byte_val: 8'h00};
          if (done) begin
            rd_valid_d = 1'b1;
            rd_data_d = rd_byte;
            len_d = len_q - 10'h001;
          end
        end else if (wr_valid) begin
          // Stalls the page fill while the source has nothing
          go = 1'b1;
          step = '{kind: nand_host_pkg::K_DATA, byte_val: wr_data};
          if (done) begin
            wr_take_d = 1'b1;
            len_d = len_q - 10'h001;
          end
        end
      end
      S_CONF: begin
        go = 1'b1;
        step.kind = nand_host_pkg::K_CMD;
        if (opc_q == OPC_ERASE) step.byte_val = nand_host_pkg::OP_ERASE_GO;
        else if (opc_q == OPC_COPY && len_q != 10'h3FF)
          step.byte_val = nand_host_pkg::OP_CB_TARGET;
        else step.byte_val = last_q ? nand_host_pkg::OP_CONFIRM
                                    : nand_host_pkg::OP_CONFIRM_MP;
        if (done) begin
          acyc_d = 3'h0;
          if (opc_q == OPC_COPY && len_q != 10'h3FF) begin
            len_d = 10'h3FF;
            st_d = S_ADDR;
          end else st_d = S_WAIT;
        end
      end
      S_CB2: begin
        // Copy-back target phase; the page never crosses the bus
        addr_d = op_addr;
        len_d = 10'h001;
        acyc_d = 3'h0;
        st_d = S_CONF;
      end
      S_END: begin
        op_done_d = 1'b1;
        ce_d = 1'b1;
        st_d = S_IDLE;
      end
      default: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= S_IDLE;
      opc_q <= 3'h0;
      addr_q <= '0;
      multi_q <= 1'b0;
      last_q <= 1'b1;
      len_q <= 10'h000;
      acyc_q <= 3'h0;
      op_ready <= 1'b0;
      op_done <= 1'b0;
      wr_take <= 1'b0;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
      ce_n <= 1'b1;
      wp_n <= 1'b0;
    end else if (clk_en) begin
      st_q <= st_d;
      opc_q <= opc_d;
      addr_q <= addr_d;
      multi_q <= multi_d;
      last_q <= last_d;
      len_q <= len_d;
      acyc_q <= acyc_d;
      op_ready <= op_ready_d;
      op_done <= op_done_d;
      wr_take <= wr_take_d;
      rd_valid <= rd_valid_d;
      rd_data <= rd_data_d;
      ce_n <= ce_d;
      wp_n <= wp_req_n;
    end
  end

  nand_step_engine u_step (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clk_en(clk_en),
    .go(go),
    .step(step),
    .done(done),
    .rd_byte(rd_byte),
    .cle(cle),
    .ale(ale),
    .we_n(we_n),
    .read_strobe_n(read_strobe_n),
    .io_out(io_out),
    .io_oe(io_oe),
    .io_in(io_in)
  );
endmodule // nand_host_ctrl
`default_nettype wire

// File: verilog/nand_host_pkg.sv
`default_nettype none
package nand_host_pkg;
  localparam logic [7:0] OP_READ_A = 8'h00;
  localparam logic [7:0] OP_READ_B = 8'h01;
  localparam logic [7:0] OP_READ_C = 8'h50;
  localparam logic [7:0] OP_CB_MP = 8'h03;
  localparam logic [7:0] OP_READ_ID = 8'h90;
  localparam logic [7:0] OP_RESET = 8'hFF;
  localparam logic [7:0] OP_STATUS = 8'h70;
  localparam logic [7:0] OP_STATUS_MP = 8'h71;
  localparam logic [7:0] OP_PROG = 8'h80;
  localparam logic [7:0] OP_CONFIRM = 8'h10;
  localparam logic [7:0] OP_CONFIRM_MP = 8'h11;
  localparam logic [7:0] OP_CB_TARGET = 8'h8A;
  localparam logic [7:0] OP_ERASE = 8'h60;
  localparam logic [7:0] OP_ERASE_GO = 8'hD0;
  localparam int ADDR_W = 27;
  localparam int PAGE_BYTES = 528;
  // Strobe phase timing in 10 ns cycles
  localparam int STROBE_NS = 30;
  localparam int CLK_NS = 10;
  localparam logic [3:0] STROBE_CYC = 4'((STROBE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [1:0] SYNC_RESET = 2'h3;
  // Byte kinds on the link
  typedef enum logic [1:0] {K_CMD = 2'h0, K_ADDR = 2'h1, K_DATA = 2'h2, K_READ = 2'h3} kind_e;
  // One step of a sequence as asked by the user side
  typedef struct packed {
    kind_e kind;
    logic [7:0] byte_val;
  } step_s;
  // Pin bundle towards the flash
  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic read_strobe_n;
    logic wp_n;
  } pins_s;
endpackage
`default_nettype wire

// File: verilog/nand_step_engine.sv
`timescale 1ns/1ps
`default_nettype none
// Drives one byte cycle on the pins: write strobe or read strobe
module nand_step_engine (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // Step request
  input wire logic go,
  input wire nand_host_pkg::step_s step,
  output logic done,
  output logic [7:0] rd_byte,
  // Pins
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic read_strobe_n,
  output logic [7:0] io_out,
  output logic io_oe,
  input wire logic [7:0] io_in
);
  logic [3:0] cnt_q, cnt_d;
  logic act_q, act_d;
  logic strobe_lo_q, strobe_lo_d;
  logic done_d;
  logic [7:0] rd_d;
  logic cle_d, ale_d, we_d, re_d, oe_d;
  logic [7:0] io_d;
  logic [7:0] io_meta_q, io_sync_q;
  nand_host_pkg::step_s st_q, st_d;

  // Read bytes come from the pins; two flops before any logic sees them
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      io_meta_q <= 8'h00;
      io_sync_q <= 8'h00;
    end else if (clk_en) begin
      io_meta_q <= io_in;
      io_sync_q <= io_meta_q;
    end
  end

  // Low phase then high phase, each STROBE_CYC long
  always_comb begin
    cnt_d = cnt_q;
    act_d = act_q;
    strobe_lo_d = strobe_lo_q;
    st_d = st_q;
    done_d = 1'b0;
    rd_d = rd_byte;
    cle_d = cle;
    ale_d = ale;
    we_d = 1'b1;
    re_d = 1'b1;
    oe_d = io_oe;
    io_d = io_out;
    // No start in the done cycle, or the caller's old step would go out twice
    if (!act_q && !done && go) begin
      act_d = 1'b1;
      st_d = step;
      strobe_lo_d = 1'b1;
      cnt_d = nand_host_pkg::STROBE_CYC;
      cle_d = (step.kind == nand_host_pkg::K_CMD);
      ale_d = (step.kind == nand_host_pkg::K_ADDR);
      oe_d = (step.kind != nand_host_pkg::K_READ);
      io_d = step.byte_val;
      we_d = (step.kind == nand_host_pkg::K_READ);
      re_d = (step.kind != nand_host_pkg::K_READ);
    end else if (act_q) begin
      cnt_d = cnt_q - 4'h1;
      if (strobe_lo_q) begin
        we_d = (st_q.kind == nand_host_pkg::K_READ);
        re_d = (st_q.kind != nand_host_pkg::K_READ);
        if (cnt_q == 4'h1) begin
          // Sample before raising the strobe; the synchroniser needs three low cycles
          if (st_q.kind == nand_host_pkg::K_READ) rd_d = io_sync_q;
          we_d = 1'b1;
          re_d = 1'b1;
          strobe_lo_d = 1'b0;
          cnt_d = nand_host_pkg::STROBE_CYC;
        end
      end else if (cnt_q == 4'h1) begin
        act_d = 1'b0;
        done_d = 1'b1;
        cle_d = 1'b0;
        ale_d = 1'b0;
      end
    end
  end

  // Registers only
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 4'h0;
      act_q <= 1'b0;
      strobe_lo_q <= 1'b0;
      st_q <= '0;
      done <= 1'b0;
      rd_byte <= 8'h00;
      cle <= 1'b0;
      ale <= 1'b0;
      we_n <= 1'b1;
      read_strobe_n <= 1'b1;
      io_oe <= 1'b0;
      io_out <= 8'h00;
    end else if (clk_en) begin
      cnt_q <= cnt_d;
      act_q <= act_d;
      strobe_lo_q <= strobe_lo_d;
      st_q <= st_d;
      done <= done_d;
      rd_byte <= rd_d;
      cle <= cle_d;
      ale <= ale_d;
      we_n <= we_d;
      read_strobe_n <= re_d;
      io_oe <= oe_d;
      io_out <= io_d;
    end
  end
endmodule // nand_step_engine
`default_nettype wire
